// >>> verilog/dds_pkg.sv
// shared constants and types of the phase accumulator core
package dds_pkg;
  localparam int WORD_W = 32;
  localparam int PHASE_W = 14;
  localparam int SAMPLE_W = 10;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 8;
  localparam int GOOD_W = 3;

  localparam int MCLK_PERIOD_NS = 5;
  // slowest legal reference period, 1 MHz
  localparam int REF_MIN_PERIOD_NS = 1000;
  // reference period that counts as recovered
  localparam int REF_RESUME_PERIOD_NS = 900;
  localparam int LOW_CYCLES_I = REF_MIN_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int RESUME_CYCLES_I = REF_RESUME_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] LOW_CYCLES = CNT_W'(LOW_CYCLES_I);
  localparam logic [CNT_W-1:0] RESUME_CYCLES = CNT_W'(RESUME_CYCLES_I);
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [GOOD_W-1:0] RESUME_EDGES = 3'h4;

  localparam logic [WORD_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_QUARTER = 14'h1000;
  localparam logic [PHASE_W-1:0] PHASE_HALF = 14'h2000;
  localparam int MAG_SHIFT = 15;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MID = 10'h200;
  localparam logic [SAMPLE_W-1:0] MAG_MAX = 10'h1FF;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 10'h3FF;

  typedef enum logic {st_run, st_down} mode_t;
endpackage

// >>> verilog/sample_fifo.sv
// flip-flop fifo with valid and ready on both sides
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic mclk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // reader takes data
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign in_ready = st.count != COUNT_FULL;
  assign out_valid = st.count != '0;
  assign out_data = st.mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == PTR_LAST) ? '0 : PTR_W'(st.wr + 1'b1);
    end
    if (pop) begin
      next_st.rd = (st.rd == PTR_LAST) ? '0 : PTR_W'(st.rd + 1'b1);
    end
    if (push && !pop) begin
      next_st.count = (PTR_W + 1)'(st.count + 1'b1);
    end else if (pop && !push) begin
      next_st.count = (PTR_W + 1)'(st.count - 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> verilog/dds_phase_accumulator_core.sv
// phase accumulator, cosine conversion and low-clock power-down
//
// Summary of operation
// - each reference rising edge outside power-down with fifo space adds tuning word to phase
// - accumulator wraps modulo full range
// - tuning word and accumulator are 32 bits
// - top 14 phase bits become cosine amplitude
// - one 10-bit sample per reference cycle
// - tuning word change never disturbs the phase
// - reference below 1 MHz forces power-down
// - no samples generated while powered down
// - recovered reference clock resumes synthesis automatically
// - new tuning word taken on strobe rising edge
// - reset clears word, phase and power-down
module dds_phase_accumulator_core #(
  parameter int WORD_W = dds_pkg::WORD_W,
  parameter int PHASE_W = dds_pkg::PHASE_W,
  parameter int SAMPLE_W = dds_pkg::SAMPLE_W,
  parameter int FIFO_DEPTH = dds_pkg::FIFO_DEPTH
) (
  input wire logic mclk, // core clock, 200 MHz
  input wire logic rst_b, // async master reset, active low
  input wire logic reference_clock_in, // sampled reference clock
  input wire logic [WORD_W-1:0] tuning_word, // loaded tuning word
  input wire logic frequency_update_strobe, // rising edge applies word
  output logic [SAMPLE_W-1:0] dac_sample, // cosine sample to converter
  output logic dac_valid, // sample available
  input wire logic dac_ready, // converter takes sample
  output logic power_down // low-clock power-down state
);
  typedef struct packed {
    logic ref_prev;
    logic strobe_prev;
    logic [WORD_W-1:0] active_word;
    logic [WORD_W-1:0] accum;
    dds_pkg::mode_t mode;
    logic [dds_pkg::CNT_W-1:0] period_cnt;
    logic [dds_pkg::GOOD_W-1:0] good_cnt;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  logic ref_rise;
  logic strobe_rise;
  logic push_valid;
  logic push_ready;
  logic push_ok;
  logic [SAMPLE_W-1:0] push_data;

  // parabolic cosine of a truncated phase, offset binary
  function automatic logic [SAMPLE_W-1:0] cos_sample(
    input logic [PHASE_W-1:0] ph
  );
    logic [PHASE_W-1:0] u;
    logic [PHASE_W-2:0] h;
    logic [PHASE_W-1:0] rest;
    logic [2*PHASE_W-2:0] prod;
    logic [2*PHASE_W-2:0] shifted;
    logic [SAMPLE_W-1:0] mag;
    u = PHASE_W'(ph + dds_pkg::PHASE_QUARTER);
    h = u[PHASE_W-2:0];
    rest = PHASE_W'(dds_pkg::PHASE_HALF - {1'b0, h});
    prod = (2*PHASE_W-1)'(h) * (2*PHASE_W-1)'(rest);
    shifted = prod >> dds_pkg::MAG_SHIFT;
    if (shifted > (2*PHASE_W-1)'(dds_pkg::MAG_MAX)) begin
      mag = dds_pkg::MAG_MAX;
    end else begin
      mag = shifted[SAMPLE_W-1:0];
    end
    if (u[PHASE_W-1]) begin
      cos_sample = SAMPLE_W'(dds_pkg::SAMPLE_MID - mag);
    end else begin
      cos_sample = SAMPLE_W'(dds_pkg::SAMPLE_MID + mag);
    end
  endfunction

  assign ref_rise = reference_clock_in && !st.ref_prev;
  assign strobe_rise = frequency_update_strobe && !st.strobe_prev;
  assign push_valid = (st.mode == dds_pkg::st_run) && ref_rise;
  assign push_ok = push_valid && push_ready;
  assign push_data = cos_sample(st.accum[WORD_W-1 -: PHASE_W]);
  assign power_down = st.mode == dds_pkg::st_down;

  always_comb begin
    next_st = st;
    next_st.ref_prev = reference_clock_in;
    next_st.strobe_prev = frequency_update_strobe;
    if (strobe_rise) begin
      // only the increment changes; phase keeps running
      next_st.active_word = tuning_word;
    end
    if (push_ok) begin
      // a full fifo holds the phase instead of losing a sample
      next_st.accum = WORD_W'(st.accum + st.active_word);
    end
    // period measured in core clock cycles, saturating
    if (ref_rise) begin
      next_st.period_cnt = '0;
    end else if (st.period_cnt != dds_pkg::CNT_MAX) begin
      next_st.period_cnt = dds_pkg::CNT_W'(st.period_cnt + 1'b1);
    end
    unique case (st.mode)
      dds_pkg::st_run: begin
        next_st.good_cnt = '0;
        if (st.period_cnt >= dds_pkg::LOW_CYCLES) begin
          next_st.mode = dds_pkg::st_down;
        end
      end
      dds_pkg::st_down: begin
        if (ref_rise) begin
          if (st.period_cnt < dds_pkg::RESUME_CYCLES) begin
            next_st.good_cnt = dds_pkg::GOOD_W'(st.good_cnt + 1'b1);
            if (next_st.good_cnt == dds_pkg::RESUME_EDGES) begin
              next_st.mode = dds_pkg::st_run;
              next_st.good_cnt = '0;
            end
          end else begin
            next_st.good_cnt = '0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(dac_valid),
    .out_ready(dac_ready),
    .out_data(dac_sample)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  property p_accum_add;
    push_ok |=> st.accum == WORD_W'($past(st.accum) + $past(st.active_word));
  endproperty
  a_accum_add: assert property (p_accum_add)
    else $error("accumulator did not add the tuning word");

  property p_wrap;
    push_ok
      && ({1'b0, st.accum} + {1'b0, st.active_word}) > {1'b0, {WORD_W{1'b1}}}
      |=> st.accum < $past(st.accum);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("accumulator overflow did not wrap");

  property p_hold_full;
    push_valid && !push_ready |=> $stable(st.accum);
  endproperty
  a_hold_full: assert property (p_hold_full)
    else $error("phase moved while sample was refused");

  property p_cos_zero;
    push_ok && st.accum[WORD_W-1 -: PHASE_W] == '0
      |-> push_data == dds_pkg::SAMPLE_MAX;
  endproperty
  a_cos_zero: assert property (p_cos_zero)
    else $error("zero phase did not give full-scale cosine");

  property p_sample_out;
    push_ok |=> dac_valid;
  endproperty
  a_sample_out: assert property (p_sample_out)
    else $error("pushed sample not offered to converter");

  property p_no_jump;
    strobe_rise && !push_ok |=> $stable(st.accum);
  endproperty
  a_no_jump: assert property (p_no_jump)
    else $error("tuning update disturbed the phase");

  property p_enter_down;
    $rose(power_down) |-> $past(st.period_cnt) >= dds_pkg::LOW_CYCLES;
  endproperty
  a_enter_down: assert property (p_enter_down)
    else $error("power-down entered without a slow clock");

  property p_slow_down;
    !power_down && st.period_cnt >= dds_pkg::LOW_CYCLES |=> power_down;
  endproperty
  a_slow_down: assert property (p_slow_down)
    else $error("slow clock did not force power-down");

  property p_no_gen;
    power_down |-> !push_valid ##1 $stable(st.accum);
  endproperty
  a_no_gen: assert property (p_no_gen)
    else $error("sample generated during power-down");

  property p_resume;
    $fell(power_down) |-> $past(ref_rise)
      && $past(st.good_cnt) == dds_pkg::GOOD_W'(dds_pkg::RESUME_EDGES - 1'b1);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resumed without enough fast edges");

  property p_word_load;
    $changed(st.active_word) |-> $past(strobe_rise);
  endproperty
  a_word_load: assert property (p_word_load)
    else $error("tuning word changed without strobe edge");

  property p_reset;
    @(posedge mclk) disable iff (1'b0)
      !rst_b |-> st.accum == '0 && st.active_word == '0 && !power_down;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear phase, word and power-down");

  property p_hyst;
    power_down && ref_rise && st.period_cnt >= dds_pkg::RESUME_CYCLES
      |=> power_down;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("marginal edge ended power-down");

  c_enter_down: cover property ($rose(power_down));
  c_resume: cover property ($fell(power_down));
  c_fifo_full: cover property (push_valid && !push_ready);
  c_update: cover property (strobe_rise ##[1:8] push_ok);
endmodule

// >>> verif/dac_model.sv
// converter model that takes cosine samples, promptly or slowly
module dac_model (
  input wire logic mclk, // core clock
  input wire logic rst_b, // reset, active low
  input wire logic [dds_pkg::SAMPLE_W-1:0] dac_sample, // sample in
  input wire logic dac_valid, // sample offered
  output logic dac_ready, // sample taken
  input wire logic stall, // hold ready low
  input wire logic slow // take every other cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [dds_pkg::SAMPLE_W-1:0] got[$];
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dac_ready <= 1'b0;
    end else begin
      if (dac_valid && dac_ready) begin
        got.push_back(dac_sample);
      end
      dac_ready <= !stall && (!slow || !dac_ready);
    end
  end
endmodule

// >>> verif/dds_phase_accumulator_core_test.sv
// self-checking bench of the phase accumulator core
module dds_phase_accumulator_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b, ref_in = 0, strobe = 0, stall = 1, slow = 0;
  logic [31:0] word = 32'h0, mw = 32'h0, acc = 32'h0;
  logic [9:0] dac_sample;
  logic dac_valid, dac_ready, power_down;
  logic [9:0] exp_q[$];
  int n_mismatch = 0, checks_done = 0;
  initial forever #2.5 mclk = ~mclk;
  dds_phase_accumulator_core dut (.mclk(mclk), .rst_b(rst_b),
    .reference_clock_in(ref_in), .tuning_word(word),
    .frequency_update_strobe(strobe), .dac_sample(dac_sample),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .power_down(power_down));
  dac_model dac (.mclk(mclk), .rst_b(rst_b), .dac_sample(dac_sample),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .stall(stall),
    .slow(slow));
  task summarize;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [9:0] cosv(input logic [31:0] a);
    logic [13:0] u;
    logic [31:0] h, m;
    u = a[31:18] + 14'h1000;
    h = {19'h0, u[12:0]};
    m = (h * (32'h2000 - h)) >> 15;
    if (m > 32'h1FF) m = 32'h1FF;
    return u[13] ? 10'h200 - m[9:0] : 10'h200 + m[9:0];
  endfunction
  task clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // each edge yields a sample unless the fifo holds 32 or gen is off
  task refs(input int n, input int half, input bit gen);
    repeat (n) begin
      ref_in <= 1'b1;
      if (gen && (!stall || exp_q.size() < 32)) begin
        exp_q.push_back(cosv(acc));
        acc = acc + mw;
      end
      clk(half);
      ref_in <= 1'b0;
      clk(half);
    end
  endtask
  task load(input logic [31:0] w);
    word <= w;
    strobe <= 1'b1;
    mw = w;
    clk(1);
    strobe <= 1'b0;
    clk(1);
  endtask
  task flush;
    int i;
    i = 0;
    stall <= 1'b0;
    while (dac.got.size() < exp_q.size() && i < 500) begin
      clk(1);
      i++;
    end
    if (i >= 500) begin
      n_mismatch++;
      summarize();
    end
    clk(4);
    chk(dac.got.size(), exp_q.size());
    while (exp_q.size() > 0 && dac.got.size() > 0) begin
      chk(dac.got.pop_front(), exp_q.pop_front());
    end
  endtask
  task s_reset;
    chk(dac_valid, 1'b0);
    chk(power_down, 1'b0);
    stall <= 1'b0;
    refs(1, 2, 1);
    clk(3);
    chk(dac.got[0], 10'h3FF);
    flush();
  endtask
  task s_tone;
    load(32'h0123_4567);
    refs(8, 3, 1);
    word <= 32'hFFFF_0000;
    refs(8, 2, 1);
    load(32'hC000_0001);
    refs(10, 1, 1);
    slow <= 1'b1;
    flush();
    slow <= 1'b0;
    word <= 32'h1357_9BDF;
    strobe <= 1'b1;
    mw = 32'h1357_9BDF;
    clk(2);
    word <= 32'h7777_0000;
    refs(6, 2, 1);
    strobe <= 1'b0;
    flush();
  endtask
  task s_full;
    stall <= 1'b1;
    clk(2);
    refs(34, 3, 1);
    chk(dac_valid, 1'b1);
    chk(dac_sample, exp_q[0]);
    flush();
    refs(3, 2, 1);
    flush();
  endtask
  task s_down;
    clk(205);
    chk(power_down, 1'b1);
    refs(3, 20, 0);
    chk(power_down, 1'b1);
    refs(2, 95, 0);
    chk(power_down, 1'b1);
    refs(5, 20, 0);
    chk(dac_valid, 1'b0);
    chk(power_down, 1'b0);
    refs(4, 3, 1);
    flush();
  endtask
  // reset in power-down with a live word: phase, word and state clear
  task s_mid_reset;
    clk(205);
    chk(power_down, 1'b1);
    rst_b <= 1'b0;
    clk(5);
    chk(power_down, 1'b0);
    chk(dac_valid, 1'b0);
    rst_b <= 1'b1;
    exp_q.delete();
    dac.got.delete();
    acc = 32'h0;
    mw = 32'h0;
    clk(2);
    refs(2, 2, 1);
    flush();
  endtask
  initial begin
    rst_b <= 1'b0;
    clk(20);
    rst_b <= 1'b1;
    clk(2);
    s_reset();
    s_tone();
    s_full();
    s_down();
    s_mid_reset();
    summarize();
  end
endmodule
